// ===== inc/hsfr_map.svh
// Overview of operation
// - OV/UV fault cuts gate, clears matching flag
// - flags readable; clear write needs condition gone
// - voltage flag returns only on clean write or manual reset
// - overcurrent cuts gate, power good, flag
// - overcurrent filter widths 0/5/10/20 us
// - insertion threshold 1x to 4x base
// - after power good use normal threshold
// - wait delay, retry, count failed retries
// - retry delay 100ms/500ms/1s/5s
// - retry limit sets status, pin, idle
// - retry mode codes select count and pin
// - mode 110 retries forever, pin after first
// - always-retry modes never idle
// - manual reset or power cycle clears failure
// - clean retry keeps gate enabled
// - overcurrent flag restored by write or retry
// - failure pin mirrors status bit, write clears
// - battery input selects undervoltage comparator
`ifndef HSFR_MAP_SVH
`define HSFR_MAP_SVH
`define HSFR_CLK_HZ        40000000
`define HSFR_NF_5US_NS     5000
`define HSFR_NF_10US_NS    10000
`define HSFR_NF_20US_NS    20000
`define HSFR_NF5_CYC       ((`HSFR_NF_5US_NS * 40) / 1000)
`define HSFR_NF10_CYC      ((`HSFR_NF_10US_NS * 40) / 1000)
`define HSFR_NF20_CYC      ((`HSFR_NF_20US_NS * 40) / 1000)
`define HSFR_DLY_100MS     100
`define HSFR_DLY_500MS     500
`define HSFR_DLY_1000MS    1000
`define HSFR_DLY_5000MS    5000
`define HSFR_MS_CYC(ms)    ((ms) * 40000)
`define HSFR_FILT_RST      2'h1
`define HSFR_LIM_RST       2'h3
`define HSFR_MODE_RST      3'h0
`define HSFR_DELAY_RST     2'h0
`define HSFR_MODE_FOREVER  3'h0
`define HSFR_MODE_FOR_PIN  3'h6
`define HSFR_MODE_NONE     3'h7
`endif

// ===== inc/hsfr_pkg.sv
package hsfr_pkg;
	// comparator results from the analog side
	typedef struct packed {
		logic overVolt;
		logic underVoltMain;
		logic underVoltBatt;
		logic ocNormal;
		logic ocInsert;
	} hsfr_cmp_t;

	// configuration bits
	typedef struct packed {
		logic [1:0] filterSel;
		logic [1:0] insertLimit;
		logic [2:0] retryMode;
		logic [1:0] retryDelay;
	} hsfr_cfg_t;

	// fault flags, active low for the three fault bits
	typedef struct packed {
		logic overvoltFaultFlag;
		logic undervoltFaultFlag;
		logic overcurrentFaultFlag;
		logic retryFailStatus;
		logic [2:0] retryCounter;
	} hsfr_stat_t;

	typedef enum logic [3:0] {
		HSFR_ON    = 4'b0001,
		HSFR_WAIT  = 4'b0010,
		HSFR_RETRY = 4'b0100,
		HSFR_IDLE  = 4'b1000
	} hsfr_state_t;
endpackage : hsfr_pkg

// ===== rtl/hsfr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsfr_map.svh"
module hsfr_ctrl #(
	parameter int unsigned MS_CYC = 40000
) (
	// clock, reset, enable
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              clkEn,
	input  wire logic              hot_manual_reset_n,
	// analog comparators and pins
	input  wire hsfr_pkg::hsfr_cmp_t cmpIn,
	input  wire logic              battery_on_in,
	input  wire logic              powerGoodQual,
	// configuration and software writes
	input  wire hsfr_pkg::hsfr_cfg_t cfgIn,
	input  wire logic              cfgWrite,
	input  wire logic              faultDetectWrite,
	input  wire logic              retryStatusWrite,
	// outputs
	output logic                   fetDriveEn,
	output logic                   power_good_out,
	output logic                   retry_fail_pin_n,
	output hsfr_pkg::hsfr_cfg_t    cfgOut,
	output hsfr_pkg::hsfr_stat_t   statOut
);
	import hsfr_pkg::*;

	logic [4:0]  syncA_ff;
	logic [4:0]  syncB_ff;
	logic [2:0]  batSync_ff;
	logic [2:0]  mrSync_ff;
	logic        ovNow, uvNow, ocRaw;
	logic [9:0]  filtCnt_ff;
	logic [9:0]  filtLen;
	logic        ocFilt;
	logic        inserting_ff;
	hsfr_cfg_t   cfg_ff;
	hsfr_stat_t  stat_ff;
	hsfr_state_t state_ff;
	logic [31:0] dlyCnt_ff;
	logic [31:0] dlyLen;
	logic        mrAct;
	logic        limitHit;

	// comparator and pin synchronisers
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			syncA_ff   <= 5'h0;
			syncB_ff   <= 5'h0;
			batSync_ff <= 3'h0;
			mrSync_ff  <= 3'h7;
		end
		else if (clkEn)
		begin
			syncA_ff   <= cmpIn;
			syncB_ff   <= syncA_ff;
			batSync_ff <= {batSync_ff[1:0], battery_on_in};
			mrSync_ff  <= {mrSync_ff[1:0], hot_manual_reset_n};
		end

	// manual reset seen low, after sync
	assign mrAct = !mrSync_ff[1];

	// decoded comparator results
	always_comb
	begin
		ovNow = syncB_ff[4];
		uvNow = batSync_ff[1] ? syncB_ff[2] : syncB_ff[3];
		ocRaw = (inserting_ff && !power_good_out) ? syncB_ff[0] : syncB_ff[1];
	end

	// filter length by select
	function automatic logic [9:0] filtCycles(input logic [1:0] sel);
		case (sel)
			2'h0: filtCycles = 10'h0;
			2'h1: filtCycles = 10'(`HSFR_NF5_CYC);
			2'h2: filtCycles = 10'(`HSFR_NF10_CYC);
			2'h3: filtCycles = 10'(`HSFR_NF20_CYC);
			default: filtCycles = 10'h0;
		endcase
	endfunction : filtCycles

	// retry delay by select
	function automatic logic [31:0] delayCycles(input logic [1:0] sel);
		case (sel)
			2'h0: delayCycles = 32'(`HSFR_DLY_100MS * MS_CYC);
			2'h1: delayCycles = 32'(`HSFR_DLY_500MS * MS_CYC);
			2'h2: delayCycles = 32'(`HSFR_DLY_1000MS * MS_CYC);
			2'h3: delayCycles = 32'(`HSFR_DLY_5000MS * MS_CYC);
			default: delayCycles = 32'(`HSFR_DLY_100MS * MS_CYC);
		endcase
	endfunction : delayCycles

	assign filtLen = filtCycles(cfg_ff.filterSel);
	assign dlyLen  = delayCycles(cfg_ff.retryDelay);

	// overcurrent must persist longer than filter width
	always_ff @(posedge clk or posedge reset)
		if (reset)
			filtCnt_ff <= 10'h0;
		else if (clkEn)
		begin
			if (!ocRaw)
				filtCnt_ff <= 10'h0;
			else if (filtCnt_ff <= filtLen)
				filtCnt_ff <= filtCnt_ff + 10'h1;
		end

	assign ocFilt = ocRaw && (filtCnt_ff > filtLen);

	// insertion window ends at first power good
	always_ff @(posedge clk or posedge reset)
		if (reset)
			inserting_ff <= 1'b1;
		else if (clkEn)
		begin
			if (mrAct)
				inserting_ff <= 1'b1;
			else if (power_good_out)
				inserting_ff <= 1'b0;
		end

	// configuration, defaults restored by manual reset
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			cfg_ff.filterSel   <= `HSFR_FILT_RST;
			cfg_ff.insertLimit <= `HSFR_LIM_RST;
			cfg_ff.retryMode   <= `HSFR_MODE_RST;
			cfg_ff.retryDelay  <= `HSFR_DELAY_RST;
		end
		else if (clkEn)
		begin
			if (mrAct)
			begin
				cfg_ff.filterSel   <= `HSFR_FILT_RST;
				cfg_ff.insertLimit <= `HSFR_LIM_RST;
				cfg_ff.retryMode   <= `HSFR_MODE_RST;
				cfg_ff.retryDelay  <= `HSFR_DELAY_RST;
			end
			else if (cfgWrite)
				cfg_ff <= cfgIn;
		end

	assign cfgOut = cfg_ff;

	// retry limit reached for counted modes
	assign limitHit = (cfg_ff.retryMode == `HSFR_MODE_NONE) ||
		((cfg_ff.retryMode != `HSFR_MODE_FOREVER) &&
		 (cfg_ff.retryMode != `HSFR_MODE_FOR_PIN) &&
		 (stat_ff.retryCounter >= cfg_ff.retryMode));

	// voltage flags: set low wins over a clearing write
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			stat_ff.overvoltFaultFlag  <= 1'b1;
			stat_ff.undervoltFaultFlag <= 1'b1;
		end
		else if (clkEn)
		begin
			if (mrAct)
			begin
				stat_ff.overvoltFaultFlag  <= 1'b1;
				stat_ff.undervoltFaultFlag <= 1'b1;
			end
			else
			begin
				if (ovNow)
					stat_ff.overvoltFaultFlag <= 1'b0;
				else if (faultDetectWrite)
					stat_ff.overvoltFaultFlag <= 1'b1;
				if (uvNow)
					stat_ff.undervoltFaultFlag <= 1'b0;
				else if (faultDetectWrite)
					stat_ff.undervoltFaultFlag <= 1'b1;
			end
		end

	// overcurrent flag
	always_ff @(posedge clk or posedge reset)
		if (reset)
			stat_ff.overcurrentFaultFlag <= 1'b1;
		else if (clkEn)
		begin
			if (mrAct)
				stat_ff.overcurrentFaultFlag <= 1'b1;
			else if (ocFilt)
				stat_ff.overcurrentFaultFlag <= 1'b0;
			else if (!ocRaw && (faultDetectWrite ||
				(state_ff == HSFR_WAIT && dlyCnt_ff == 32'h0)))
				stat_ff.overcurrentFaultFlag <= 1'b1;
		end

	// retry state machine and counter
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			state_ff             <= HSFR_ON;
			dlyCnt_ff            <= 32'h0;
			stat_ff.retryCounter <= 3'h0;
		end
		else if (clkEn)
		begin
			if (mrAct)
			begin
				state_ff             <= HSFR_ON;
				dlyCnt_ff            <= 32'h0;
				stat_ff.retryCounter <= 3'h0;
			end
			else
				case (state_ff)
					HSFR_ON:
						if (ocFilt)
						begin
							state_ff  <= limitHit ? HSFR_IDLE : HSFR_WAIT;
							dlyCnt_ff <= dlyLen - 32'h1;
						end
					HSFR_WAIT:
						if (dlyCnt_ff != 32'h0)
							dlyCnt_ff <= dlyCnt_ff - 32'h1;
						else
						begin
							// window covers gate, sync and filter latency
							state_ff  <= HSFR_RETRY;
							dlyCnt_ff <= 32'(filtLen) + 32'h6;
						end
					HSFR_RETRY:
						if (ocFilt)
						begin
							if (stat_ff.retryCounter != 3'h7)
								stat_ff.retryCounter <= stat_ff.retryCounter + 3'h1;
							state_ff  <= (limitHit || ((cfg_ff.retryMode != 3'h0) &&
								(cfg_ff.retryMode != `HSFR_MODE_FOR_PIN) &&
								(stat_ff.retryCounter + 3'h1 >= cfg_ff.retryMode)))
								? HSFR_IDLE : HSFR_WAIT;
							dlyCnt_ff <= dlyLen - 32'h1;
						end
						else if (dlyCnt_ff != 32'h0)
							dlyCnt_ff <= dlyCnt_ff - 32'h1;
						else
							state_ff <= HSFR_ON;
					HSFR_IDLE:
						state_ff <= HSFR_IDLE;
					default:
						state_ff <= HSFR_ON;
				endcase
		end

	// failure status: set wins over software clear
	always_ff @(posedge clk or posedge reset)
		if (reset)
			stat_ff.retryFailStatus <= 1'b0;
		else if (clkEn)
		begin
			if (mrAct)
				stat_ff.retryFailStatus <= 1'b0;
			else if ((state_ff != HSFR_IDLE) && ocFilt && limitHit && (state_ff == HSFR_ON))
				stat_ff.retryFailStatus <= 1'b1;
			else if (state_ff == HSFR_RETRY && ocFilt &&
				(cfg_ff.retryMode != `HSFR_MODE_FOREVER) &&
				((cfg_ff.retryMode == `HSFR_MODE_FOR_PIN) ||
				 (stat_ff.retryCounter + 3'h1 >= cfg_ff.retryMode)))
				stat_ff.retryFailStatus <= 1'b1;
			else if (retryStatusWrite)
				stat_ff.retryFailStatus <= 1'b0;
			else if (cfg_ff.retryMode == `HSFR_MODE_FOR_PIN && faultDetectWrite && !ocRaw)
				stat_ff.retryFailStatus <= 1'b0;
		end

	assign statOut = stat_ff;

	// gate and power-good outputs
	always_ff @(posedge clk or posedge reset)
		if (reset)
		begin
			fetDriveEn       <= 1'b0;
			power_good_out   <= 1'b0;
			retry_fail_pin_n <= 1'b1;
		end
		else if (clkEn)
		begin
			fetDriveEn <= !ovNow && !uvNow && !ocFilt && !mrAct &&
				(state_ff == HSFR_ON || state_ff == HSFR_RETRY);
			power_good_out <= !ovNow && !uvNow && !ocFilt && !mrAct &&
				state_ff == HSFR_ON && fetDriveEn && powerGoodQual;
			retry_fail_pin_n <= !stat_ff.retryFailStatus;
		end
endmodule : hsfr_ctrl
`default_nettype wire

// ===== tb/hsfr_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hsfr_ctrl_properties #(
	parameter int unsigned MS_CYC = 40000
) (
	// clock and resets
	input wire logic                clk,
	input wire logic                reset,
	input wire logic                clkEn,
	input wire logic                hot_manual_reset_n,
	// inputs of the block
	input wire hsfr_pkg::hsfr_cmp_t cmpIn,
	input wire logic                battery_on_in,
	input wire logic                powerGoodQual,
	input wire hsfr_pkg::hsfr_cfg_t cfgIn,
	input wire logic                cfgWrite,
	input wire logic                faultDetectWrite,
	input wire logic                retryStatusWrite,
	// outputs of the block
	input wire logic                fetDriveEn,
	input wire logic                power_good_out,
	input wire logic                retry_fail_pin_n,
	input wire hsfr_pkg::hsfr_cfg_t cfgOut,
	input wire hsfr_pkg::hsfr_stat_t statOut
);
	import hsfr_pkg::*;
	// one domain, manual reset holds defaults
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset || !hot_manual_reset_n);
	// fault reactions
	a_ov_cut_gate: assert property (cmpIn.overVolt[*3] |-> ##[0:4] !fetDriveEn)
		else $error("overvoltage left gate on");
	a_ov_write_refused: assert property (cmpIn.overVolt[*4] ##0 faultDetectWrite
		|=> !statOut.overvoltFaultFlag) else $error("flag cleared under fault");
	a_vflag_sticky: assert property (!statOut.overvoltFaultFlag && !faultDetectWrite
		|=> !statOut.overvoltFaultFlag) else $error("flag rose without write");
	a_uv_batt_sel: assert property ((battery_on_in && cmpIn.underVoltBatt)[*4]
		|-> ##[0:4] !statOut.undervoltFaultFlag) else $error("battery uv missed");
	a_oc_cut_all: assert property ($fell(statOut.overcurrentFaultFlag)
		|-> ##[0:2] (!fetDriveEn && !power_good_out)) else $error("oc left outputs on");
	a_pin_mirror: assert property ($stable(statOut.retryFailStatus)
		|-> retry_fail_pin_n != statOut.retryFailStatus) else $error("pin not status");
	a_idle_off: assert property ((statOut.retryFailStatus && cfgOut.retryMode != 3'h0
		&& cfgOut.retryMode != 3'h6)[*3] |-> !fetDriveEn) else $error("idle gate on");
	a_mr_defaults: assert property (@(posedge clk) disable iff (reset)
		!hot_manual_reset_n[*4] |-> (cfgOut == 9'h0e0 && statOut[3:0] == 4'h0
		&& !fetDriveEn)) else $error("manual reset kept state");
	// main scenarios
	c_fail: cover property ($rose(statOut.retryFailStatus));
	c_ov: cover property ($fell(statOut.overvoltFaultFlag));
	c_retry: cover property ($rose(fetDriveEn));
endmodule : hsfr_ctrl_properties
bind hsfr_ctrl hsfr_ctrl_properties #(.MS_CYC(MS_CYC)) i_hsfr_ctrl_properties (.*);
`default_nettype wire

// ===== tb/hsfr_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsfr_analog_model (
	// sense level in 50 mV steps, {ov, uv main, uv battery}
	input  wire logic [2:0]          senseLvl,
	input  wire logic [2:0]          volts,
	// device side
	input  wire logic                fetDriveEn,
	input  wire hsfr_pkg::hsfr_cfg_t cfgOut,
	output var hsfr_pkg::hsfr_cmp_t  cmpOut
);
	import hsfr_pkg::*;
	// a short draws current only while the gate is driven
	assign cmpOut.overVolt = volts[2];
	assign cmpOut.underVoltMain = volts[1];
	assign cmpOut.underVoltBatt = volts[0];
	assign cmpOut.ocNormal = fetDriveEn && senseLvl > 3'h1;
	assign cmpOut.ocInsert = fetDriveEn && senseLvl > {1'b0, cfgOut.insertLimit} + 3'h1;
endmodule : hsfr_analog_model
`default_nettype wire

// ===== tb/test_hsfr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_hsfr_ctrl;
	import hsfr_pkg::*;
	localparam int unsigned MS = 4;
	// bench signals
	logic       clk, reset, clkEn, hotResetN, batt, pgq, cfgWr, fdWr, rsWr, fet, pg, pinN;
	logic [2:0] lvl, volts;
	hsfr_cfg_t  cfgIn, cfgOut;
	hsfr_cmp_t  cmpIn;
	hsfr_stat_t st;
	int         n_mismatch, cmp_count, n;
	int         dly[4] = '{100, 500, 1000, 5000};
	// block and its analog side
	hsfr_ctrl #(.MS_CYC(MS)) i_hsfr_ctrl (.clk(clk), .reset(reset), .clkEn(clkEn),
		.hot_manual_reset_n(hotResetN), .cmpIn(cmpIn), .battery_on_in(batt),
		.powerGoodQual(pgq), .cfgIn(cfgIn), .cfgWrite(cfgWr), .faultDetectWrite(fdWr),
		.retryStatusWrite(rsWr), .fetDriveEn(fet), .power_good_out(pg),
		.retry_fail_pin_n(pinN), .cfgOut(cfgOut), .statOut(st));
	hsfr_analog_model i_hsfr_analog_model (.senseLvl(lvl), .volts(volts),
		.fetDriveEn(fet), .cfgOut(cfgOut), .cmpOut(cmpIn));
	// verdict
	task automatic close_out();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic tick(int c);
		repeat (c) @(posedge clk);
	endtask : tick
	// one-cycle strobe: 0 config, 1 fault clear, 2 status clear
	task automatic wr(int k);
		@(posedge clk);
		{rsWr, fdWr, cfgWr} <= 3'h1 << k;
		@(posedge clk);
		{rsWr, fdWr, cfgWr} <= 3'h0;
	endtask : wr
	task automatic setCfg(logic [8:0] c);
		cfgIn <= c;
		wr(0);
	endtask : setCfg
	// bounded wait for a gate level, n counts cycles
	task automatic waitFet(logic v, int lim);
		n = 0;
		while (fet !== v)
		begin
			@(posedge clk);
			n++;
			if (n > lim)
			begin
				check("gate wait", 9'h0, 9'h1);
				close_out();
			end
		end
	endtask : waitFet
	task automatic mr();
		hotResetN <= 1'b0;
		tick(200);
		hotResetN <= 1'b1;
		tick(4);
		check("mr", {cfgOut, st.retryCounter}, {9'h0e0, 3'h0});
		waitFet(1'b1, 20);
	endtask : mr
	// clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// main sequence
	initial
	begin
		{reset, clkEn, hotResetN, batt, pgq, cfgWr, fdWr, rsWr} = 8'he0;
		{lvl, volts, cfgIn} = 15'h00e0;
		tick(3);
		reset <= 1'b0;
		tick(2);
		check("reset", {st, pinN}, 9'h0e1);
		waitFet(1'b1, 20);
		// voltage flags stay low until a clean write
		volts <= 3'h4;
		tick(6);
		check("ov", {fet, st.overvoltFaultFlag}, 9'h0);
		wr(1);
		volts <= 3'h0;
		tick(6);
		check("ov kept", st.overvoltFaultFlag, 9'h0);
		wr(1);
		tick(2);
		check("ov clr", st.overvoltFaultFlag, 9'h1);
		volts <= 3'h1;
		tick(6);
		check("uv main", st.undervoltFaultFlag, 9'h1);
		batt <= 1'b1;
		tick(6);
		check("uv batt", st.undervoltFaultFlag, 9'h0);
		volts <= 3'h0;
		tick(4);
		wr(1);
		waitFet(1'b1, 20);
		// spikes below each filter width
		for (int f = 1; f < 4; f++)
		begin
			setCfg({f[1:0], 7'h60});
			lvl <= 3'h7;
			tick(150 << (f - 1));
			lvl <= 3'h0;
			tick(6);
			check("spike", st.overcurrentFaultFlag, 9'h1);
		end
		// raised limit until power good
		setCfg(9'h0e0);
		lvl <= 3'h4;
		tick(300);
		check("insert", st.overcurrentFaultFlag, 9'h1);
		pgq <= 1'b1;
		tick(10);
		check("pg", pg, 9'h1);
		tick(300);
		check("oc", {st.overcurrentFaultFlag, fet, pg}, 9'h0);
		// retry spacing per delay code
		for (int d = 0; d < 4; d++)
		begin
			setCfg({7'h38, d[1:0]});
			waitFet(1'b1, 25000);
			waitFet(1'b0, 1000);
			waitFet(1'b1, 25000);
			check("delay", {8'h0, n + 8 >= dly[d] * MS && n <= dly[d] * MS + 8}, 9'h1);
			tick(5);
			check("retry flag", st.overcurrentFaultFlag, 9'h1);
		end
		lvl <= 3'h0;
		tick(600);
		check("clean", {fet, st.retryFailStatus}, 9'h2);
		// counter starts from zero for the limited modes
		mr();
		// limited retries end idle
		for (int m = 1; m < 6; m++)
		begin
			setCfg({4'h3, m[2:0], 2'h0});
			lvl <= 3'h7;
			waitFet(1'b0, 20);
			repeat (m)
			begin
				waitFet(1'b1, 600);
				waitFet(1'b0, 20);
			end
			lvl <= 3'h0;
			tick(600);
			check("count", st.retryCounter, 9'(m));
			check("idle", {fet, st.retryFailStatus, pinN}, 9'h2);
			wr(2);
			tick(2);
			check("stat clr", {st.retryFailStatus, pinN, fet}, 9'h2);
			mr();
		end
		// no retry at all
		setCfg(9'h07c);
		lvl <= 3'h7;
		waitFet(1'b0, 20);
		tick(600);
		check("none", {fet, pinN}, 9'h0);
		lvl <= 3'h0;
		mr();
		// forever with failure pin
		setCfg(9'h078);
		lvl <= 3'h7;
		waitFet(1'b0, 20);
		waitFet(1'b1, 600);
		waitFet(1'b0, 20);
		tick(4);
		check("pin first", pinN, 9'h0);
		lvl <= 3'h0;
		waitFet(1'b1, 600);
		tick(10);
		wr(1);
		tick(2);
		check("forever", {fet, pinN, st.overcurrentFaultFlag}, 9'h7);
		close_out();
	end
endmodule : test_hsfr_ctrl
`default_nettype wire
